// ===== core/hbp_pkg.sv
package hbp_pkg;
	// host address map, word select is addr[4:2]
	localparam logic [2:0] SEL_DATA0 = 3'h3;
	localparam logic [2:0] SEL_FIFO = 3'h6;
	localparam logic [2:0] SEL_CFG = 3'h7;
	localparam logic [4:0] FIFO_WIN_ADDR = 5'h18;
	// byte order bits: [2:0] per pair, [3] fifo window
	localparam int CFG_FIFO_BE_BIT = 3;
	localparam logic [3:0] CFG_RESET = 4'h0;
	localparam logic [1:0] FIFO_TGT = 2'h3;
	// host side register offsets
	localparam logic [7:0] OFF_CMD = 8'h00;
	localparam logic [7:0] OFF_ADDR = 8'h04;
	localparam logic [7:0] OFF_WDATA = 8'h08;
	localparam logic [7:0] OFF_RDATA = 8'h0c;
	localparam logic [7:0] OFF_STAT = 8'h10;
	localparam logic [7:0] OFF_MODE = 8'h14;
	localparam logic [4:0] MODE_RESET = 5'h07;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	// strobe timing
	localparam int CLK_NS = 25;
	localparam int STROBE_NS = 32;
	localparam int GAP_NS = 13;
	localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
	// device answers through two sync flops, capture, hold and drive registers
	localparam int DEV_LAT_CYC = 6;
	localparam int HOLD_CYC = 3;
	localparam logic [3:0] ACT_CNT = 4'(STROBE_CYC + DEV_LAT_CYC - 1);
	localparam logic [3:0] HOLD_CNT = 4'(HOLD_CYC + GAP_CYC - 1);

	function automatic logic [31:0] swap32(input logic [31:0] w, input logic be);
		swap32 = be ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
	endfunction
endpackage

// ===== core/hbp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface hbp_if;
	logic cs;
	logic rd_dir;
	logic cycle_enable_strobe;
	logic [4:0] addr;
	logic [15:0] host_d;
	logic host_d_oe_n;
	logic [15:0] dev_d;
	logic [1:0] dev_d_oe_n;
	logic [15:0] bus_d;
	// wire level: device byte lanes win while enabled, else host; a lane nobody drives
	// reads inverted so that late or missing read data cannot pass for the right value
	assign bus_d[7:0] = !dev_d_oe_n[0] ? dev_d[7:0] : (host_d_oe_n ? ~host_d[7:0] : host_d[7:0]);
	assign bus_d[15:8] = !dev_d_oe_n[1] ? dev_d[15:8] : (host_d_oe_n ? ~host_d[15:8] : host_d[15:8]);
	modport dev (input cs, rd_dir, cycle_enable_strobe, addr, bus_d, output dev_d, dev_d_oe_n);
	modport host (output cs, rd_dir, cycle_enable_strobe, addr, host_d, host_d_oe_n, input bus_d);
endinterface
`default_nettype wire

// ===== core/host_bus_port.sv
`timescale 1ns/1ps
`default_nettype none
module host_bus_port
	import hbp_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	hbp_if.dev port,
	input wire logic cs_high,
	input wire logic rd_high,
	input wire logic wr_high,
	input wire logic rdwr_mode,
	input wire logic bus8,
	output logic [15:0] int_addr,
	output logic [31:0] int_wdata,
	output logic int_wr,
	output logic int_rd,
	input wire logic [31:0] int_rdata,
	output logic [31:0] fifo_wdata,
	output logic fifo_push,
	output logic fifo_pop,
	input wire logic [31:0] fifo_rdata,
	output logic [3:0] lock
);
	import hbp_pkg::*;

	logic [2:0] cs_s, rd_s, en_s;
	logic [4:0] a_s0, a_s1;
	logic [15:0] d_s0, d_s1;
	logic [4:0] acap_reg;
	logic [15:0] idx_reg [3];
	logic [3:0] cfg_reg;
	logic [31:0] asm_reg [4];
	logic [31:0] hold_reg [4];
	logic [1:0] wcnt_reg [4];
	logic [1:0] rcnt_reg [4];
	logic write_ok_reg;
	logic cap_pend_reg;
	logic [1:0] cap_tgt_reg;
	logic rd_now, rd_was, wr_now, wr_was;
	logic rd_lead, rd_trail, wr_lead, wr_trail;
	logic [1:0] last_part;
	logic [31:0] drv_word;

	function automatic logic on(input logic lvl, input logic high);
		on = (lvl == high);
	endfunction

	// target 0..2 data pairs, 3 fifo window
	function automatic logic is_data(input logic [4:0] a);
		is_data = (a[4:2] >= SEL_DATA0) && (a[4:2] <= SEL_FIFO);
	endfunction

	function automatic logic [1:0] tgt(input logic [4:0] a);
		tgt = 2'(a[4:2] - SEL_DATA0);
	endfunction

	function automatic logic [31:0] put(input logic [31:0] w, input logic [1:0] p, input logic [15:0] d,
		input logic b8);
		logic [31:0] r;
		r = w;
		if (b8) begin
			r[8*p +: 8] = d[7:0];
		end else begin
			r[16*p[1] +: 16] = d;
		end
		put = r;
	endfunction

	always_ff @(posedge aclk) begin
		cs_s <= {cs_s[1:0], port.cs};
		rd_s <= {rd_s[1:0], port.rd_dir};
		en_s <= {en_s[1:0], port.cycle_enable_strobe};
		a_s0 <= port.addr;
		a_s1 <= a_s0;
		d_s0 <= port.bus_d;
		d_s1 <= d_s0;
	end

	always_comb begin
		rd_now = on(cs_s[1], cs_high) && (rdwr_mode ? on(en_s[1], wr_high) && on(rd_s[1], rd_high)
			: on(rd_s[1], rd_high));
		rd_was = on(cs_s[2], cs_high) && (rdwr_mode ? on(en_s[2], wr_high) && on(rd_s[2], rd_high)
			: on(rd_s[2], rd_high));
		wr_now = on(cs_s[1], cs_high) && on(en_s[1], wr_high) && !(rdwr_mode && on(rd_s[1], rd_high));
		wr_was = on(cs_s[2], cs_high) && on(en_s[2], wr_high) && !(rdwr_mode && on(rd_s[2], rd_high));
		rd_lead = rd_now && !rd_was;
		rd_trail = !rd_now && rd_was;
		wr_lead = wr_now && !wr_was;
		wr_trail = !wr_now && wr_was;
		last_part = bus8 ? 2'h3 : 2'h1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acap_reg <= 5'h00;
		end else if (rd_lead || wr_lead) begin
			acap_reg <= a_s1;
		end
	end

	// host cycle handling and the internal port
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 4; i++) begin
				asm_reg[i] <= 32'h0;
				hold_reg[i] <= 32'h0;
				wcnt_reg[i] <= 2'h0;
				rcnt_reg[i] <= 2'h0;
			end
			for (int i = 0; i < 3; i++) begin
				idx_reg[i] <= 16'h0;
			end
			cfg_reg <= CFG_RESET;
			write_ok_reg <= 1'b0;
			cap_pend_reg <= 1'b0;
			cap_tgt_reg <= 2'h0;
			int_addr <= 16'h0;
			int_wdata <= 32'h0;
			int_wr <= 1'b0;
			int_rd <= 1'b0;
			fifo_wdata <= 32'h0;
			fifo_push <= 1'b0;
			fifo_pop <= 1'b0;
			lock <= 4'h0;
		end else begin
			int_wr <= 1'b0;
			int_rd <= 1'b0;
			fifo_push <= 1'b0;
			fifo_pop <= 1'b0;
			cap_pend_reg <= 1'b0;
			if (rd_lead) begin
				write_ok_reg <= 1'b1;
				if (is_data(a_s1) && rcnt_reg[tgt(a_s1)] == 2'h0) begin
					lock[tgt(a_s1)] <= 1'b1;
					cap_pend_reg <= 1'b1;
					cap_tgt_reg <= tgt(a_s1);
					if (tgt(a_s1) != FIFO_TGT) begin
						int_addr <= idx_reg[tgt(a_s1)];
					end
				end
			end
			if (cap_pend_reg) begin
				hold_reg[cap_tgt_reg] <= (cap_tgt_reg == FIFO_TGT) ? fifo_rdata : int_rdata;
			end
			if (rd_trail && is_data(acap_reg)) begin
				if (rcnt_reg[tgt(acap_reg)] == last_part) begin
					rcnt_reg[tgt(acap_reg)] <= 2'h0;
					lock[tgt(acap_reg)] <= 1'b0;
					if (tgt(acap_reg) == FIFO_TGT) begin
						fifo_pop <= 1'b1;
					end else begin
						int_rd <= 1'b1;
					end
				end else begin
					rcnt_reg[tgt(acap_reg)] <= rcnt_reg[tgt(acap_reg)] + 2'h1;
				end
			end
			if (wr_trail && write_ok_reg) begin
				if (is_data(acap_reg)) begin
					asm_reg[tgt(acap_reg)] <= put(asm_reg[tgt(acap_reg)], acap_reg[1:0], d_s1, bus8);
					if (wcnt_reg[tgt(acap_reg)] == last_part) begin
						wcnt_reg[tgt(acap_reg)] <= 2'h0;
						if (tgt(acap_reg) == FIFO_TGT) begin
							fifo_wdata <= swap32(put(asm_reg[FIFO_TGT], acap_reg[1:0], d_s1, bus8),
								cfg_reg[CFG_FIFO_BE_BIT]);
							fifo_push <= 1'b1;
						end else begin
							int_addr <= idx_reg[tgt(acap_reg)];
							int_wdata <= swap32(put(asm_reg[tgt(acap_reg)], acap_reg[1:0], d_s1, bus8),
								cfg_reg[tgt(acap_reg)]);
							int_wr <= 1'b1;
						end
					end else begin
						wcnt_reg[tgt(acap_reg)] <= wcnt_reg[tgt(acap_reg)] + 2'h1;
					end
				end else if (acap_reg[4:2] == SEL_CFG) begin
					// config parts beyond the low byte carry nothing and are accepted silently
					cfg_reg <= 4'(put({28'h0, cfg_reg}, acap_reg[1:0], d_s1, bus8));
				end else if (!acap_reg[1]) begin
					idx_reg[acap_reg[3:2]] <= 16'(put({16'h0, idx_reg[acap_reg[3:2]]}, acap_reg[1:0], d_s1,
						bus8));
				end
			end
		end
	end

	always_comb begin
		if (is_data(acap_reg)) begin
			drv_word = swap32(hold_reg[tgt(acap_reg)], (tgt(acap_reg) == FIFO_TGT) ?
				cfg_reg[CFG_FIFO_BE_BIT] : cfg_reg[tgt(acap_reg)]);
		end else if (acap_reg[4:2] == SEL_CFG) begin
			drv_word = {28'h0, cfg_reg};
		end else begin
			drv_word = {16'h0, idx_reg[acap_reg[3:2]]};
		end
	end

	// drive follows the synchronised strobe, one flop stage behind it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port.dev_d <= 16'h0;
			port.dev_d_oe_n <= 2'h3;
		end else begin
			port.dev_d <= bus8 ? {8'h00, drv_word[8*acap_reg[1:0] +: 8]} : drv_word[16*acap_reg[1] +: 16];
			port.dev_d_oe_n[0] <= !rd_now;
			port.dev_d_oe_n[1] <= !(rd_now && !bus8);
		end
	end
endmodule // host_bus_port
`default_nettype wire

// ===== core/hbp_host.sv
`timescale 1ns/1ps
`default_nettype none
module hbp_host
	import hbp_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	hbp_if.host port,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);
	import hbp_pkg::*;

	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_SETUP = 2'b01, ST_ACT = 2'b11, ST_HOLD = 2'b10} state_t;
	state_t state_reg;
	logic [3:0] cnt_reg;
	logic [4:0] mode_reg; // {bus8, rdwr_mode, wr_high, rd_high, cs_high}
	logic [4:0] addr_reg;
	logic [15:0] wd_reg;
	logic [15:0] rd_reg;
	logic op_wr_reg;
	logic start_reg;
	logic aw_have_reg, w_have_reg;
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [15:0] bus_s0, bus_s1;

	always_ff @(posedge aclk) begin
		bus_s0 <= port.bus_d;
		bus_s1 <= bus_s0;
	end

	// register slave; a command write while busy is dropped
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h0;
			bvalid <= 1'b0;
			bresp <= RESP_OK;
			mode_reg <= MODE_RESET;
			addr_reg <= 5'h00;
			wd_reg <= 16'h0;
			op_wr_reg <= 1'b0;
			start_reg <= 1'b0;
		end else begin
			start_reg <= 1'b0;
			if (awvalid && awready) begin
				aw_have_reg <= 1'b1;
				awaddr_reg <= awaddr;
				awready <= 1'b0;
			end
			if (wvalid && wready) begin
				w_have_reg <= 1'b1;
				wdata_reg <= wdata;
				wready <= 1'b0;
			end
			if (aw_have_reg && w_have_reg && !bvalid) begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				bvalid <= 1'b1;
				bresp <= RESP_OK;
				unique case (awaddr_reg)
					OFF_CMD: begin
						if (state_reg == ST_IDLE && wdata_reg[0]) begin
							start_reg <= 1'b1;
							op_wr_reg <= wdata_reg[1];
						end
					end
					OFF_ADDR: addr_reg <= wdata_reg[4:0];
					OFF_WDATA: wd_reg <= wdata_reg[15:0];
					OFF_MODE: mode_reg <= wdata_reg[4:0];
					OFF_RDATA, OFF_STAT: ;
					default: bresp <= RESP_ERR;
				endcase
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= RESP_OK;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rresp <= RESP_OK;
			unique case (araddr)
				OFF_CMD: rdata <= {30'h0, op_wr_reg, 1'b0};
				OFF_ADDR: rdata <= {27'h0, addr_reg};
				OFF_WDATA: rdata <= {16'h0, wd_reg};
				OFF_RDATA: rdata <= {16'h0, rd_reg};
				OFF_STAT: rdata <= {31'h0, state_reg != ST_IDLE || start_reg};
				OFF_MODE: rdata <= {27'h0, mode_reg};
				default: begin
					rdata <= 32'h0;
					rresp <= RESP_ERR;
				end
			endcase
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// one host bus cycle per command; pins carry the configured levels
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 4'h0;
			rd_reg <= 16'h0;
			port.cs <= 1'b0;
			port.rd_dir <= 1'b0;
			port.cycle_enable_strobe <= 1'b0;
			port.addr <= 5'h00;
			port.host_d <= 16'h0;
			port.host_d_oe_n <= 1'b1;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					port.cs <= !mode_reg[0];
					port.rd_dir <= !mode_reg[1];
					port.cycle_enable_strobe <= !mode_reg[2];
					port.host_d_oe_n <= 1'b1;
					if (start_reg) begin
						state_reg <= ST_SETUP;
						port.cs <= mode_reg[0];
						port.addr <= addr_reg;
						port.host_d <= wd_reg;
						port.host_d_oe_n <= !op_wr_reg;
						// direction mode: the read line is direction, asserted means read
						port.rd_dir <= mode_reg[3] ? (op_wr_reg ? !mode_reg[1] : mode_reg[1]) : !mode_reg[1];
					end
				end
				ST_SETUP: begin
					state_reg <= ST_ACT;
					cnt_reg <= ACT_CNT;
					if (op_wr_reg || mode_reg[3]) begin
						port.cycle_enable_strobe <= mode_reg[2];
					end else begin
						port.rd_dir <= mode_reg[1];
					end
				end
				ST_ACT: begin
					cnt_reg <= cnt_reg - 4'h1;
					if (cnt_reg == 4'h0) begin
						state_reg <= ST_HOLD;
						cnt_reg <= HOLD_CNT;
						port.cycle_enable_strobe <= !mode_reg[2];
						if (!mode_reg[3]) begin
							port.rd_dir <= !mode_reg[1];
						end
						if (!op_wr_reg) begin
							rd_reg <= mode_reg[4] ? {8'h00, bus_s1[7:0]} : bus_s1;
						end
					end
				end
				ST_HOLD: begin
					cnt_reg <= cnt_reg - 4'h1;
					if (cnt_reg == 4'h0) begin
						state_reg <= ST_IDLE;
					end
				end
			endcase
		end
	end
endmodule // hbp_host
`default_nettype wire

// ===== dv/hbp_checker.sv
`timescale 1ns/1ps
`default_nettype none
module hbp_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic cs,
	input wire logic rd_dir,
	input wire logic cycle_enable_strobe,
	input wire logic [4:0] addr,
	input wire logic host_d_oe_n,
	input wire logic [1:0] dev_d_oe_n,
	input wire logic cs_high,
	input wire logic rd_high,
	input wire logic wr_high,
	input wire logic rdwr_mode,
	input wire logic bus8
);
	logic stb;
	logic rd_cyc;
	// chip select is part of the term so a strobe polarity swap while idle is not a cycle
	assign stb = (cs == cs_high) && ((cycle_enable_strobe == wr_high) || (!rdwr_mode && rd_dir == rd_high));
	assign rd_cyc = stb && host_d_oe_n;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	upper_lane_quiet_a: assert property (bus8 |-> dev_d_oe_n[1])
		else $error("upper lane driven in byte mode");
	drive_in_read_a: assert property ($fell(dev_d_oe_n[0]) |-> rd_cyc)
		else $error("read data driven outside a read");
	read_drive_due_a: assert property ($rose(rd_cyc) |-> ##[1:6] !dev_d_oe_n[0])
		else $error("read data not driven in time");
	wide_lanes_a: assert property (!bus8 && !dev_d_oe_n[0] |-> !dev_d_oe_n[1])
		else $error("half word read drives one lane");
	write_no_drive_a: assert property (stb && !host_d_oe_n |-> dev_d_oe_n == 2'h3)
		else $error("device drives during a write");
	read_release_a: assert property ($fell(stb) && host_d_oe_n |-> ##[1:5] dev_d_oe_n == 2'h3)
		else $error("read data not released");
	strobe_width_a: assert property ($rose(stb) |-> stb [*8] ##1 !stb)
		else $error("strobe width wrong");
	cycle_hold_a: assert property ($rose(stb) |-> ##1 $stable(addr) [*7])
		else $error("address moved in a cycle");
endmodule // hbp_checker
`default_nettype wire

// ===== dv/test_indexed_host_bus_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_indexed_host_bus_port;
	import hbp_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] awaddr = 8'h0, araddr = 8'h0;
	logic [31:0] wdata = 32'h0, int_rdata = 32'h0, fifo_rdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic cs_high = 1'b1, rd_high = 1'b1, wr_high = 1'b1, rdwr_mode = 1'b0, bus8 = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, int_wr, int_rd, fifo_push, fifo_pop;
	logic [1:0] bresp, rresp, rr;
	logic [31:0] rdata, int_wdata, fifo_wdata, last_wr, last_push, s;
	logic [15:0] int_addr, last_addr, q;
	logic [3:0] lock;
	int fails = 0, checks_done = 0, n_wr = 0, n_rd = 0, n_push = 0, n_pop = 0, cyc = 0;
	hbp_if bus();
	host_bus_port u_host_bus_port(.aclk, .aresetn, .port(bus), .cs_high, .rd_high, .wr_high, .rdwr_mode, .bus8,
		.int_addr, .int_wdata, .int_wr, .int_rd, .int_rdata, .fifo_wdata, .fifo_push, .fifo_pop, .fifo_rdata, .lock);
	hbp_host u_hbp_host(.aclk, .aresetn, .port(bus), .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
	hbp_checker u_hbp_checker(.aclk, .aresetn, .cs(bus.cs), .rd_dir(bus.rd_dir),
		.cycle_enable_strobe(bus.cycle_enable_strobe), .addr(bus.addr), .host_d_oe_n(bus.host_d_oe_n),
		.dev_d_oe_n(bus.dev_d_oe_n), .cs_high, .rd_high, .wr_high, .rdwr_mode, .bus8);
	always #12.5 aclk = ~aclk;
	always @(posedge aclk) begin
		if (int_wr === 1'b1) begin
			n_wr++;
			last_wr = int_wdata;
			last_addr = int_addr;
		end
		if (int_rd === 1'b1)
			n_rd++;
		if (fifo_push === 1'b1) begin
			n_push++;
			last_push = fifo_wdata;
		end
		if (fifo_pop === 1'b1)
			n_pop++;
	end
	// generous: the whole run needs under a thousand cycles
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			end_sim();
		end
	end
	task automatic end_sim;
		if (fails == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want) begin
			fails++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid)
				break;
		end
		rr = bresp;
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid)
				break;
		end
		d = rdata;
		rr = rresp;
		rready <= 1'b0;
	endtask
	// one host bus cycle; read data lands in q
	task automatic cmd(input logic wr, input logic [4:0] a, input logic [15:0] d);
		axi_wr(OFF_ADDR, {27'h0, a});
		axi_wr(OFF_WDATA, {16'h0, d});
		axi_wr(OFF_CMD, {30'h0, wr, 1'b1});
		do
			axi_rd(OFF_STAT, s);
		while (s[0] === 1'b1);
		axi_rd(OFF_RDATA, s);
		q = s[15:0];
	endtask
	task automatic s_locked;
		axi_rd(OFF_MODE, s);
		check(s, 32'h07);
		axi_rd(8'h20, s);
		check({30'h0, rr}, {30'h0, RESP_ERR});
		axi_wr(8'h24, 32'h0);
		check({30'h0, rr}, {30'h0, RESP_ERR});
		cmd(1'b1, 5'h0c, 16'h1111);
		cmd(1'b1, 5'h0e, 16'h2222);
		check(32'(n_wr), 32'h0);
		cmd(1'b0, 5'h00, 16'h0);
	endtask
	task automatic s_pair_write;
		cmd(1'b1, 5'h00, 16'h0012);
		cmd(1'b1, 5'h02, 16'hffff);
		cmd(1'b1, 5'h0e, 16'h1234);
		check(32'(n_wr), 32'h0);
		cmd(1'b1, 5'h0c, 16'h5678);
		check(last_wr, 32'h12345678);
		check({16'h0, last_addr}, 32'h12);
		cmd(1'b1, 5'h0c, 16'haaaa);
		cmd(1'b1, 5'h0e, 16'hbbbb);
		check(last_wr, 32'hbbbbaaaa);
		check(32'(n_wr), 32'h2);
	endtask
	task automatic s_pair_read;
		int_rdata <= 32'hcafe0123;
		cmd(1'b0, 5'h0c, 16'h0);
		check({16'h0, q}, 32'h0123);
		check({31'h0, lock[0]}, 32'h1);
		check(32'(n_rd), 32'h0);
		int_rdata <= 32'h0;
		cmd(1'b0, 5'h0e, 16'h0);
		check({16'h0, q}, 32'hcafe);
		check({31'h0, lock[0]}, 32'h0);
		check(32'(n_rd), 32'h1);
	endtask
	task automatic s_fifo;
		cmd(1'b1, 5'h1c, 16'h0008);
		cmd(1'b1, 5'h18, 16'h1122);
		cmd(1'b1, 5'h1a, 16'h3344);
		check(last_push, 32'h22114433);
		check(32'(n_push), 32'h1);
		cmd(1'b1, 5'h0c, 16'h0001);
		cmd(1'b1, 5'h0e, 16'h0002);
		check(last_wr, 32'h00020001);
		fifo_rdata <= 32'h44332211;
		cmd(1'b0, 5'h18, 16'h0);
		check({16'h0, q}, 32'h3344);
		check({31'h0, lock[3]}, 32'h1);
		cmd(1'b0, 5'h1a, 16'h0);
		check({16'h0, q}, 32'h1122);
		check(32'(n_pop), 32'h1);
	endtask
	// strobe polarity flips only while chip select stays inactive, then chip select flips
	// only once the synchronisers hold the strobes inactive, so no false cycle is seen
	task automatic s_byte;
		@(posedge aclk);
		rd_high <= 1'b0;
		wr_high <= 1'b0;
		rdwr_mode <= 1'b1;
		bus8 <= 1'b1;
		axi_wr(OFF_MODE, 32'h19);
		repeat (3) @(posedge aclk);
		cs_high <= 1'b0;
		axi_wr(OFF_MODE, 32'h18);
		cmd(1'b1, 5'h1c, 16'h0001);
		for (int i = 3; i >= 0; i--) begin
			check(32'(n_wr), 32'h3);
			cmd(1'b1, 5'h0c + 5'(i), 16'(8'h11 * (i + 1)));
		end
		check(last_wr, 32'h11223344);
		check(32'(n_wr), 32'h4);
		int_rdata <= 32'h11223344;
		for (int i = 0; i < 4; i++) begin
			cmd(1'b0, 5'h0c + 5'(i), 16'h0);
			check({24'h0, q[7:0]}, 32'(8'h11 * (i + 1)));
		end
		check(32'(n_rd), 32'h2);
	endtask
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		s_locked();
		s_pair_write();
		s_pair_read();
		s_fifo();
		s_byte();
		end_sim();
	end
endmodule // test_indexed_host_bus_port
`default_nettype wire
